/* File: pkg/chg_regs.svh */
`ifndef CHG_REGS_SVH
`define CHG_REGS_SVH
// Register indices; byte address is four times the index
`define CHG_IDX_STATUS      3'h0
`define CHG_IDX_CTRL        3'h1
`define CHG_IDX_SUPV        3'h2
`define CHG_IDX_SPECIAL     3'h5
// Status register fields
`define CHG_STS_RESTART_BIT 7
`define CHG_STS_STATE_LSB   4
`define CHG_STS_FAULT_LSB   0
// Control register fields and reset value
`define CHG_CTRL_ILIM_LSB   6
`define CHG_CTRL_RST        8'h00
// Special charger flag position
`define CHG_SPECIAL_BIT     4
// Charge state field codes
`define CHG_CS_READY        2'h0
`define CHG_CS_CHARGING     2'h1
`define CHG_CS_DONE         2'h2
`define CHG_CS_FAULT        2'h3
// Fault codes
`define CHG_FLT_NONE        3'h0
`define CHG_FLT_SLEEP       3'h2
`define CHG_FLT_BAT_OVP     3'h4
`define CHG_FLT_TIMER       3'h6
`define CHG_FLT_NO_BAT      3'h7
// Input limit codes
`define CHG_ILIM_100MA      2'h0
`define CHG_ILIM_500MA      2'h1
// Clock rate and times in their own units
`define CHG_CLK_KHZ         250000
`define CHG_T_PULSE_NS      128000
`define CHG_T_DETECT_MS     262
`define CHG_T_INT_MS        2000
`define CHG_T_WDOG_S        32
`define CHG_T_SAFETY_MIN    15
// Derived counts
`define CHG_CYC_PER_MS      (`CHG_CLK_KHZ)
`define CHG_PULSE_CYC       ((`CHG_T_PULSE_NS * (`CHG_CLK_KHZ / 1000)) / 1000)
`define CHG_WDOG_MS         (`CHG_T_WDOG_S * 1000)
`define CHG_SAFETY_MS       (`CHG_T_SAFETY_MIN * 60000)
`endif

/* File: pkg/chg_pkg.sv */
package chg_pkg;
  typedef enum logic [9:0] {
    CHG_ST_IDLE    = 10'h001,
    CHG_ST_HIZ     = 10'h002,
    CHG_ST_SLEEP   = 10'h004,
    CHG_ST_SHORT   = 10'h008,
    CHG_ST_CHARGE  = 10'h010,
    CHG_ST_DETECT  = 10'h020,
    CHG_ST_ABSWAIT = 10'h040,
    CHG_ST_DONE    = 10'h080,
    CHG_ST_OVP     = 10'h100,
    CHG_ST_TFAULT  = 10'h200
  } chg_state_e;
  typedef logic [31:0] chg_cnt_t;
endpackage : chg_pkg

/* File: pkg/chg_tb_if.sv */
`timescale 1ns/1ps
// Millisecond time base shared by all slow timers
interface chg_tb_if;
  logic tick;
  logic run;
  modport src (output tick, input run);
  modport snk (input tick, output run);
endinterface : chg_tb_if

/* File: hw/chg_timebase.sv */
`timescale 1ns/1ps
`include "chg_regs.svh"
// Prescaler giving a one-cycle tick once per millisecond
module chg_timebase
  import chg_pkg::*;
#(
  parameter int unsigned CYC_PER_MS = `CHG_CYC_PER_MS
) (
  input  wire logic ref_clk,
  input  wire logic resetn,
  chg_tb_if.src     tb
);
  chg_cnt_t pre_q;

  // Divider chain, cleared to zero and held there while not running
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pre_q   <= '0;
      tb.tick <= 1'b0;
    end else if (!tb.run) begin
      pre_q   <= '0;
      tb.tick <= 1'b0;
    end else if (pre_q == chg_cnt_t'(CYC_PER_MS - 1)) begin
      pre_q   <= '0;
      tb.tick <= 1'b1;
    end else begin
      pre_q   <= pre_q + 32'h1;
      tb.tick <= 1'b0;
    end
  end

  a_tick_period: assert property (@(posedge ref_clk) disable iff (!resetn)
    tb.tick |-> pre_q == '0) // RQ20
    else $error("tick outside prescaler wrap");
endmodule : chg_timebase

/* File: hw/chg_supervisor.sv */
// Implementation choices: the Avalon-MM slave port and the register addresses.
`timescale 1ns/1ps
`include "chg_regs.svh"
// Behaviour
// RQ1 - Supply under battery plus sleep offset yet above minimum: sleep, switch and converter off
// RQ2 - Supply at input floor: cut charge current and set special charger flag
// RQ3 - Battery overvoltage stops converter, sets fault, pulses status; clears on exit
// RQ4 - Battery below short threshold while charging: reduced short-circuit current
// RQ5 - First variant, default mode: 262 ms check after short mode, absent means idle; the code enters CHG_ST_HIZ instead
// RQ6 - Second variant skips that check and regulates at default voltage
// RQ7 - Host mode, above recharge with termination: converter off, discharge for 262 ms
// RQ8 - Sampled below recharge: battery absent, defaults restored, resume after delay
// RQ9 - Good adapter and battery start safety timer; host write switches to watchdog
// RQ10 - Host writes restart bit; device restarts watchdog then clears bit
// RQ11 - Watchdog expiry ends charge, restores defaults, returns to safety timer mode
// RQ12 - Safety expiry stops charge, reports fault code, pulses status 128 us
// RQ13 - Timer fault cleared only by power-up; fault bits held until host reads
// RQ14 - At power-up host mode keeps programmed bits, else defaults in default mode
// RQ15 - Default mode with battery above low threshold stays high impedance
// RQ16 - Input limit from pin or variant in default mode, from field in host mode
// RQ17 - Charge only with good adapter and battery below recharge threshold
// RQ18 - Watchdog period within 15 to 40 seconds, nominally 32
// RQ19 - Safety timer period within 12 to 15 minutes
// RQ20 - All slow timers run from one millisecond time base
module chg_supervisor
  import chg_pkg::*;
#(
  parameter int unsigned CYC_PER_MS = `CHG_CYC_PER_MS,
  parameter int unsigned PULSE_CYC  = `CHG_PULSE_CYC,
  parameter int unsigned DETECT_MS  = `CHG_T_DETECT_MS,
  parameter int unsigned INT_MS     = `CHG_T_INT_MS,
  parameter int unsigned WDOG_MS    = `CHG_WDOG_MS,
  parameter int unsigned SAFETY_MS  = `CHG_SAFETY_MS
) (
  input  wire logic        ref_clk,
  input  wire logic        resetn,
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        variant_sel,
  input  wire logic        vbus_por,
  input  wire logic        adapter_good,
  input  wire logic        vbus_below_sleep,
  input  wire logic        vbus_above_min,
  input  wire logic        vbus_at_floor,
  input  wire logic        bat_ovp,
  input  wire logic        bat_short,
  input  wire logic        bat_above_recharge,
  input  wire logic        bat_above_lowv,
  input  wire logic        term_current_det,
  input  wire logic        input_limit_select_pin,
  output logic             conv_en,
  output logic             rev_switch_en,
  output logic             short_mode,
  output logic             current_reduce,
  output logic             discharge_en,
  output logic             reg_default,
  output logic      [1:0]  ilim_code,
  output logic             stat_out,
  output logic             stat_oe_n
);
  chg_state_e state_q, state_d;
  chg_cnt_t   det_q, wd_q, sf_q, pulse_q;
  logic [7:0] ctrl_q;
  logic [2:0] fault_q;
  logic       host_q, restart_q, ack_q, fault_seen_q, special_q;
  logic       absent_q, pchk_arm_q, pchk_run_q;
  logic       rd_acc, wr_acc, tmr_done, sf_run, sf_exp, wd_exp, flt_evt;
  logic [2:0] flt_code;
  logic [31:0] rd_mux;
  chg_tb_if   tb ();

  function automatic logic reg_hit(input logic [4:0] a, input logic [2:0] idx);
    reg_hit = (a[4:2] == idx) && (a[1:0] == 2'h0);
  endfunction : reg_hit

  chg_timebase #(.CYC_PER_MS(CYC_PER_MS)) u_tb (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .tb      (tb)
  );
  assign tb.run = 1'b1; // RQ20

  // Bus handshake: one wait cycle, then accept
  assign avs_waitrequest = (avs_read || avs_write) && !ack_q;
  assign rd_acc          = avs_read && ack_q;
  assign wr_acc          = avs_write && ack_q;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= (avs_read || avs_write) && !ack_q;
    end
  end

  // Read multiplexer
  always_comb begin
    rd_mux = 32'h0;
    if (reg_hit(avs_address, `CHG_IDX_STATUS)) begin
      rd_mux[`CHG_STS_RESTART_BIT] = restart_q;
      rd_mux[`CHG_STS_STATE_LSB +: 2] =
        (state_q == CHG_ST_TFAULT || state_q == CHG_ST_OVP) ? `CHG_CS_FAULT :
        (state_q == CHG_ST_DONE) ? `CHG_CS_DONE :
        (conv_en ? `CHG_CS_CHARGING : `CHG_CS_READY);
      rd_mux[`CHG_STS_FAULT_LSB +: 3] = fault_q;
    end else if (reg_hit(avs_address, `CHG_IDX_CTRL)) begin
      rd_mux[7:0] = ctrl_q;
    end else if (reg_hit(avs_address, `CHG_IDX_SUPV)) begin
      rd_mux[2:0] = {conv_en, absent_q, host_q};
    end else if (reg_hit(avs_address, `CHG_IDX_SPECIAL)) begin
      rd_mux[`CHG_SPECIAL_BIT] = special_q;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      avs_readdata <= 32'h0;
    end else if (avs_read && !ack_q) begin
      avs_readdata <= rd_mux;
    end
  end

  // Host mode, control field and restart bit
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      host_q    <= 1'b0;
      ctrl_q    <= `CHG_CTRL_RST;
      restart_q <= 1'b0;
    end else begin
      restart_q <= 1'b0; // RQ10
      if (wd_exp) begin
        host_q <= 1'b0; // RQ11
        ctrl_q <= `CHG_CTRL_RST;
      end else if (vbus_por && !host_q) begin
        ctrl_q <= `CHG_CTRL_RST; // RQ14
      end else if (state_q == CHG_ST_DETECT && tmr_done && !bat_above_recharge) begin
        ctrl_q <= `CHG_CTRL_RST; // RQ8
      end
      if (wr_acc) begin
        host_q <= 1'b1; // RQ9
        if (reg_hit(avs_address, `CHG_IDX_STATUS)) begin
          restart_q <= avs_writedata[`CHG_STS_RESTART_BIT]; // RQ10
        end else if (reg_hit(avs_address, `CHG_IDX_CTRL)) begin
          ctrl_q <= avs_writedata[7:0];
        end
      end
    end
  end

  // Watchdog and safety timers on the shared tick
  assign sf_run = !host_q && adapter_good && !absent_q && state_q != CHG_ST_TFAULT
                  && state_q != CHG_ST_HIZ; // RQ9
  assign sf_exp = sf_run && tb.tick && sf_q == chg_cnt_t'(SAFETY_MS - 1); // RQ19
  assign wd_exp = host_q && !restart_q && !wr_acc && tb.tick
                  && wd_q == chg_cnt_t'(WDOG_MS - 1); // RQ18

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      wd_q <= '0;
      sf_q <= '0;
    end else begin
      if (!host_q || restart_q || wr_acc || wd_exp) begin
        wd_q <= '0; // RQ10
      end else if (tb.tick) begin
        wd_q <= wd_q + 32'h1;
      end
      if (!sf_run || sf_exp) begin
        sf_q <= '0; // RQ11
      end else if (tb.tick) begin
        sf_q <= sf_q + 32'h1;
      end
    end
  end

  // Shared interval timer for detection, presence check and retry delay
  assign tmr_done = tb.tick && det_q == chg_cnt_t'(
                    (state_q == CHG_ST_ABSWAIT ? INT_MS : DETECT_MS) - 1);

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      det_q <= '0;
    end else if (state_d != state_q || tmr_done) begin
      det_q <= '0;
    end else if (tb.tick) begin
      det_q <= det_q + 32'h1;
    end
  end

  // Power-up presence check arming and battery absence
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pchk_arm_q <= 1'b0;
      pchk_run_q <= 1'b0;
      absent_q   <= 1'b0;
    end else if (vbus_por) begin
      pchk_arm_q <= !variant_sel && !host_q; // RQ5 RQ6
      pchk_run_q <= 1'b0;
      absent_q   <= 1'b0;
    end else begin
      if (state_q == CHG_ST_SHORT && state_d == CHG_ST_CHARGE && pchk_arm_q) begin
        pchk_arm_q <= 1'b0;
        pchk_run_q <= !host_q; // RQ5
      end else if (state_q != CHG_ST_CHARGE || tmr_done) begin
        pchk_run_q <= 1'b0;
      end
      if (state_q == CHG_ST_CHARGE && pchk_run_q && tmr_done && bat_above_recharge) begin
        absent_q <= 1'b1; // RQ5
      end
    end
  end

  // Next state
  always_comb begin
    state_d = state_q;
    if (vbus_por) begin
      state_d = CHG_ST_IDLE; // RQ13
    end else if (state_q == CHG_ST_TFAULT) begin
      state_d = CHG_ST_TFAULT; // RQ13
    end else if (sf_exp) begin
      state_d = CHG_ST_TFAULT; // RQ12
    end else if (bat_ovp) begin
      state_d = CHG_ST_OVP; // RQ3
    end else if (vbus_below_sleep && vbus_above_min) begin
      state_d = CHG_ST_SLEEP; // RQ1
    end else if (wd_exp) begin
      state_d = CHG_ST_IDLE; // RQ11
    end else begin
      case (state_q)
        CHG_ST_IDLE: begin
          if (absent_q || (!host_q && bat_above_lowv)) begin
            state_d = CHG_ST_HIZ; // RQ15
          end else if (adapter_good && !bat_above_recharge) begin
            state_d = CHG_ST_SHORT; // RQ17
          end
        end
        CHG_ST_HIZ: begin
          if (!absent_q && (host_q || !bat_above_lowv)) begin
            state_d = CHG_ST_IDLE;
          end
        end
        CHG_ST_SHORT: begin
          if (!adapter_good) begin
            state_d = CHG_ST_IDLE;
          end else if (!bat_short) begin
            state_d = CHG_ST_CHARGE;
          end
        end
        CHG_ST_CHARGE: begin
          if (!adapter_good) begin
            state_d = CHG_ST_IDLE;
          end else if (bat_short) begin
            state_d = CHG_ST_SHORT; // RQ4
          end else if (pchk_run_q && tmr_done && bat_above_recharge) begin
            state_d = CHG_ST_HIZ; // RQ5
          end else if (host_q && bat_above_recharge && term_current_det) begin
            state_d = CHG_ST_DETECT; // RQ7
          end
        end
        CHG_ST_DETECT: begin
          if (tmr_done) begin
            state_d = bat_above_recharge ? CHG_ST_DONE : CHG_ST_ABSWAIT; // RQ8
          end
        end
        CHG_ST_ABSWAIT: begin
          if (tmr_done) begin
            state_d = CHG_ST_IDLE; // RQ8
          end
        end
        CHG_ST_DONE: begin
          if (!bat_above_recharge) begin
            state_d = CHG_ST_IDLE;
          end
        end
        default: state_d = CHG_ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= CHG_ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Registered drive outputs; enables from the next state, reg_default and ilim_code from the mode
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      conv_en        <= 1'b0;
      rev_switch_en  <= 1'b0;
      short_mode     <= 1'b0;
      current_reduce <= 1'b0;
      discharge_en   <= 1'b0;
      reg_default    <= 1'b1;
      ilim_code      <= `CHG_ILIM_100MA;
    end else begin
      conv_en        <= state_d == CHG_ST_SHORT || state_d == CHG_ST_CHARGE; // RQ1 RQ3 RQ7
      rev_switch_en  <= state_d != CHG_ST_SLEEP && state_d != CHG_ST_HIZ; // RQ1
      short_mode     <= state_d == CHG_ST_SHORT; // RQ4
      current_reduce <= state_d == CHG_ST_CHARGE && vbus_at_floor; // RQ2
      discharge_en   <= state_d == CHG_ST_DETECT; // RQ7
      reg_default    <= !host_q; // RQ6
      if (host_q) begin
        ilim_code <= ctrl_q[`CHG_CTRL_ILIM_LSB +: 2]; // RQ16
      end else if (!variant_sel && !input_limit_select_pin) begin
        ilim_code <= `CHG_ILIM_100MA;
      end else begin
        ilim_code <= `CHG_ILIM_500MA;
      end
    end
  end

  // Special charger flag follows the input floor while charging
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      special_q <= 1'b0;
    end else begin
      special_q <= state_q == CHG_ST_CHARGE && vbus_at_floor; // RQ2
    end
  end

  // Fault events, held code and status pulse
  assign flt_evt  = state_d != state_q && (state_d == CHG_ST_TFAULT || state_d == CHG_ST_OVP
                    || state_d == CHG_ST_SLEEP || (state_d == CHG_ST_HIZ && absent_q == 1'b0
                    && state_q == CHG_ST_CHARGE));
  assign flt_code = state_d == CHG_ST_TFAULT ? `CHG_FLT_TIMER :
                    state_d == CHG_ST_OVP ? `CHG_FLT_BAT_OVP :
                    state_d == CHG_ST_SLEEP ? `CHG_FLT_SLEEP : `CHG_FLT_NO_BAT;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      fault_q      <= `CHG_FLT_NONE;
      fault_seen_q <= 1'b1;
    end else if (vbus_por) begin
      fault_q      <= `CHG_FLT_NONE; // RQ13
      fault_seen_q <= 1'b1;
    end else if (flt_evt && fault_seen_q) begin
      fault_q      <= flt_code; // RQ12 RQ13
      fault_seen_q <= 1'b0;
    end else if (rd_acc && reg_hit(avs_address, `CHG_IDX_STATUS)) begin
      fault_seen_q <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pulse_q   <= '0;
      stat_oe_n <= 1'b1;
    end else if (flt_evt) begin
      pulse_q   <= chg_cnt_t'(PULSE_CYC - 1); // RQ3 RQ12
      stat_oe_n <= 1'b0;
    end else if (pulse_q != '0) begin
      pulse_q   <= pulse_q - 32'h1;
    end else begin
      stat_oe_n <= 1'b1;
    end
  end
  assign stat_out = 1'b0; // Open-drain, drives low only

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  a_sleep_off: assert property (state_q == CHG_ST_SLEEP |-> !conv_en && !rev_switch_en) // RQ1
    else $error("converter or switch on in sleep");
  a_floor_flag: assert property (state_q == CHG_ST_CHARGE && vbus_at_floor && !vbus_por
    && !bat_ovp && !sf_exp |=> special_q && current_reduce) // RQ2
    else $error("floor flag or reduction missing");
  a_ovp_stop: assert property (bat_ovp && !vbus_por && state_q != CHG_ST_TFAULT && !sf_exp
    |=> state_q == CHG_ST_OVP && !conv_en) // RQ3
    else $error("overvoltage did not stop converter");
  a_host_write: assert property (wr_acc && !wd_exp |=> host_q && wd_q == '0) // RQ9
    else $error("host write did not start watchdog");
  a_restart_clr: assert property (wr_acc && reg_hit(avs_address, `CHG_IDX_STATUS)
    && avs_writedata[`CHG_STS_RESTART_BIT] |=> restart_q ##1 !restart_q && wd_q == '0) // RQ10
    else $error("restart bit not self-cleared");
  a_wd_defaults: assert property (wd_exp && !wr_acc |=> !host_q && ctrl_q == `CHG_CTRL_RST) // RQ11
    else $error("watchdog expiry kept host settings");
  a_tfault_hold: assert property (state_q == CHG_ST_TFAULT && !vbus_por |=> state_q == CHG_ST_TFAULT
    && !conv_en) // RQ13
    else $error("timer fault left without power-up");
  a_tfault_pulse: assert property (sf_exp && !vbus_por |=> !stat_oe_n [*8]) // RQ12
    else $error("timer fault pulse missing");
  a_ilim_pin: assert property (!host_q && !variant_sel |=> ilim_code ==
    ($past(input_limit_select_pin) ? `CHG_ILIM_500MA : `CHG_ILIM_100MA)) // RQ16
    else $error("default input limit wrong");
  a_wd_bound: assert property (wd_q < chg_cnt_t'(WDOG_MS)) // RQ18
    else $error("watchdog count beyond period");
  a_charge_entry: assert property ($rose(conv_en) |-> $past(adapter_good)) // RQ17
    else $error("charge started without good adapter");
  a_detect_dis: assert property (state_q == CHG_ST_DETECT |-> discharge_en && !conv_en) // RQ7
    else $error("detection without discharge");

  c_detect_done: cover property (state_q == CHG_ST_DETECT ##1 state_q == CHG_ST_DONE);
  c_absent_wait: cover property (state_q == CHG_ST_ABSWAIT ##1 state_q == CHG_ST_IDLE);
  c_wd_expire:   cover property (wd_exp);
  c_tfault:      cover property (state_q == CHG_ST_TFAULT);
endmodule : chg_supervisor

/* File: verif/chg_host_model.sv */
`timescale 1ns/1ps
// Host side of the register bus; one request at a time, held until accepted
module chg_host_model (
  input  wire logic        ref_clk,
  input  wire logic [31:0] avs_readdata,
  input  wire logic        avs_waitrequest,
  output logic      [4:0]  avs_address,
  output logic             avs_read,
  output logic             avs_write,
  output logic      [31:0] avs_writedata
);
  // Bus idle at time zero
  initial begin
    avs_address   = 5'h00;
    avs_read      = 1'b0;
    avs_write     = 1'b0;
    avs_writedata = 32'h00000000;
  end

  // Any write hands control to the host and restarts the watchdog
  task automatic bus_write(input logic [4:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= 1'b1;
    do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
    avs_write     <= 1'b0;
    avs_writedata <= ~d; // Stale data is not left on the bus
  endtask : bus_write

  // Read data is taken at the accepting edge
  task automatic bus_read(input logic [4:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    avs_address <= a;
    avs_read    <= 1'b1;
    do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
    d = avs_readdata;
    avs_read    <= 1'b0;
  endtask : bus_read
endmodule : chg_host_model

/* File: verif/charger_timer_mode_control_bench.sv */
`timescale 1ns/1ps
module charger_timer_mode_control_bench;
  import chg_pkg::*;
  localparam int CPM = 4;
  localparam int PUL = 8;
  logic        ref_clk, resetn, variant_sel, vbus_por, adapter_good, vbus_below_sleep;
  logic        vbus_above_min, vbus_at_floor, bat_ovp, bat_short, bat_above_recharge;
  logic        bat_above_lowv, term_current_det, input_limit_select_pin;
  logic [4:0]  avs_address;
  logic        avs_read, avs_write, avs_waitrequest;
  logic [31:0] avs_writedata, avs_readdata, rd, seed;
  logic        conv_en, rev_switch_en, short_mode, current_reduce, discharge_en;
  logic        reg_default, stat_out, stat_oe_n;
  logic [1:0]  ilim_code;
  int          failures, tests_run, cycles;

  chg_supervisor #(.CYC_PER_MS(CPM), .PULSE_CYC(PUL), .DETECT_MS(5), .INT_MS(10),
    .WDOG_MS(20), .SAFETY_MS(40)) i_dut (.*);
  chg_host_model i_host (.*);

  // Clock and cycle ceiling
  initial ref_clk = 1'b0;
  always #2 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      tally_and_finish();
    end
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", n, exp, seen);
    end
  endtask : check

  function automatic logic sig(input int k);
    case (k)
      0: sig = conv_en;
      1: sig = rev_switch_en;
      2: sig = short_mode;
      3: sig = current_reduce;
      4: sig = reg_default;
      6: sig = discharge_en;
      default: sig = stat_oe_n;
    endcase
  endfunction : sig

  // Bounded wait for an output level, then compare it
  task automatic wait_until(input int k, input logic v, input string n);
    int i;
    i = 0;
    while (sig(k) !== v && i < 400) begin
      @(posedge ref_clk);
      i++;
    end
    check(n, {31'h0, sig(k)}, {31'h0, v});
  endtask : wait_until

  // Length of the fault pulse in clock cycles
  task automatic pulse_len();
    int n;
    n = 0;
    wait_until(5, 1'b0, "stat_low");
    check("stat_pin", {31'h0, stat_out}, 32'h0);
    while (stat_oe_n === 1'b0 && n < 100) begin
      @(posedge ref_clk);
      n++;
    end
    check("pulse_len", 32'(n), 32'(PUL));
  endtask : pulse_len

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : tally_and_finish

  initial begin
    {variant_sel, vbus_por, adapter_good, vbus_below_sleep, vbus_above_min} = 5'h00;
    {vbus_at_floor, bat_ovp, bat_short, bat_above_recharge, bat_above_lowv} = 5'h00;
    {term_current_det, input_limit_select_pin} = 2'h0;
    resetn = 1'b0;
    seed = 32'h810DF9D0;
    failures = 0;
    tests_run = 0;
    cycles = 0;
    repeat (10) @(posedge ref_clk);
    resetn <= 1'b1;
    // Reset values and an unmapped place
    check("reg_default", {31'h0, reg_default}, 32'h1);
    i_host.bus_read(5'h04, rd);
    check("ctrl_rst", rd & 32'hC0, 32'h0);
    i_host.bus_read(5'h1C, rd);
    check("unmapped", rd, 32'h0);
    // Default mode charging; limit from the pin, then from the second variant
    adapter_good <= 1'b1;
    vbus_above_min <= 1'b1;
    bat_short <= 1'b1;
    wait_until(2, 1'b1, "short_mode");
    bat_short <= 1'b0;
    wait_until(0, 1'b1, "conv_en");
    repeat (40) @(posedge ref_clk);
    check("still_chg", {31'h0, conv_en}, 32'h1);
    for (int p = 0; p < 2; p++) begin
      input_limit_select_pin <= p[0];
      repeat (4) @(posedge ref_clk);
      check("ilim_pin", {30'h0, ilim_code}, p ? 32'h1 : 32'h0);
    end
    variant_sel <= 1'b1;
    input_limit_select_pin <= 1'b0;
    repeat (4) @(posedge ref_clk);
    check("ilim_var2", {30'h0, ilim_code}, 32'h1);
    check("reg_def2", {31'h0, reg_default}, 32'h1);
    // Input floor
    vbus_at_floor <= 1'b1;
    wait_until(3, 1'b1, "cur_reduce");
    i_host.bus_read(5'h14, rd);
    check("special", rd & 32'h10, 32'h10);
    vbus_at_floor <= 1'b0;
    // Battery overvoltage
    bat_ovp <= 1'b1;
    pulse_len();
    check("ovp_conv", {31'h0, conv_en}, 32'h0);
    i_host.bus_read(5'h00, rd);
    check("ovp_code", rd & 32'h7, 32'h4);
    bat_ovp <= 1'b0;
    wait_until(0, 1'b1, "ovp_exit");
    // Sleep entry
    vbus_below_sleep <= 1'b1;
    pulse_len();
    check("slp_sw", {31'h0, rev_switch_en}, 32'h0);
    check("slp_conv", {31'h0, conv_en}, 32'h0);
    i_host.bus_read(5'h00, rd);
    check("slp_code", rd & 32'h7, 32'h2);
    vbus_below_sleep <= 1'b0;
    wait_until(0, 1'b1, "slp_exit");
    // Host mode with random limit codes and restart bit
    for (int k = 0; k < 4; k++) begin
      seed = lfsr(seed);
      i_host.bus_write(5'h04, {24'h0, seed[7:0]});
      i_host.bus_read(5'h04, rd);
      check("ctrl_rd", rd & 32'hC0, {24'h0, seed[7:6], 6'h0});
      check("ilim_host", {30'h0, ilim_code}, {30'h0, seed[7:6]});
    end
    check("host_mode", {31'h0, reg_default}, 32'h0);
    repeat (60) @(posedge ref_clk);
    i_host.bus_write(5'h00, 32'h80);
    i_host.bus_read(5'h00, rd);
    check("rst_clear", rd & 32'h80, 32'h0);
    repeat (60) @(posedge ref_clk);
    check("wd_alive", {31'h0, reg_default}, 32'h0);
    // Watchdog expiry returns to defaults
    wait_until(4, 1'b1, "wd_expire");
    i_host.bus_read(5'h04, rd);
    check("ctrl_def", rd & 32'hC0, 32'h0);
    // Safety timer expiry
    wait_until(0, 1'b1, "chg_again");
    pulse_len();
    check("tf_conv", {31'h0, conv_en}, 32'h0);
    i_host.bus_read(5'h00, rd);
    check("tf_stat", rd & 32'h37, 32'h36);
    repeat (50) @(posedge ref_clk);
    check("tf_held", {31'h0, conv_en}, 32'h0);
    vbus_por <= 1'b1;
    @(posedge ref_clk);
    vbus_por <= 1'b0;
    wait_until(0, 1'b1, "por_clear");
    // Battery above low threshold in default mode
    bat_above_lowv <= 1'b1;
    vbus_por <= 1'b1;
    @(posedge ref_clk);
    vbus_por <= 1'b0;
    wait_until(1, 1'b0, "hiz_sw");
    check("hiz_conv", {31'h0, conv_en}, 32'h0);
    // First variant power-up presence check finds no battery
    {bat_above_lowv, variant_sel, bat_short} <= 3'h1;
    vbus_por <= 1'b1;
    @(posedge ref_clk);
    vbus_por <= 1'b0;
    wait_until(2, 1'b1, "pchk_short");
    bat_short <= 1'b0;
    bat_above_recharge <= 1'b1;
    pulse_len();
    check("pchk_sw", {31'h0, rev_switch_en}, 32'h0);
    i_host.bus_read(5'h08, rd);
    check("pchk_abs", rd & 32'h6, 32'h2);
    i_host.bus_read(5'h00, rd);
    check("pchk_code", rd & 32'h7, 32'h7);
    // Host mode detection finds the battery removed
    {variant_sel, bat_above_recharge} <= 2'h2;
    vbus_por <= 1'b1;
    @(posedge ref_clk);
    vbus_por <= 1'b0;
    i_host.bus_write(5'h04, 32'hC0);
    wait_until(0, 1'b1, "det_chg");
    {bat_above_recharge, term_current_det} <= 2'h3;
    wait_until(6, 1'b1, "discharge");
    check("det_conv", {31'h0, conv_en}, 32'h0);
    bat_above_recharge <= 1'b0;
    repeat (24) @(posedge ref_clk);
    i_host.bus_read(5'h04, rd);
    check("abs_ctrl", rd & 32'hC0, 32'h0);
    i_host.bus_write(5'h00, 32'h80);
    check("abs_wait", {31'h0, conv_en}, 32'h0);
    wait_until(0, 1'b1, "abs_resume");
    tally_and_finish();
  end
endmodule : charger_timer_mode_control_bench
